// *** design/dmp_mem_port.sv ***
// Debug memory port: register slave, sizing, laning and packed transfers
module dmp_mem_port #(
  parameter int ADDR_W         = 12,
  parameter bit MULTI_SIZE     = 1'b1,
  parameter bit BIG_ENDIAN     = 1'b0,
  parameter bit MISALIGN_FAULT = 1'b1
) (
  // Clock, reset, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // Write address channel
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  // Write data channel
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  // Write response channel
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  // Read address channel
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  // Read data channel
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  // Memory side
  output dmp_pkg::dmp_mreq_s    mem_req,
  output logic                  mem_valid,
  input  wire logic             mem_ack,
  input  wire logic             mem_err,
  input  wire logic [31:0]      mem_rdata,
  // Status
  output logic                  sticky_error_flag
);
  // Control status word and data path registers
  logic [2:0]  size_q, size_d;          // Transfer size
  logic [1:0]  inc_q, inc_d;            // Increment mode
  logic [31:0] tar_q, tar_d;            // Transfer address
  logic [31:0] drw_q, drw_d;            // Data word
  logic        sticky_q, sticky_d;      // Sticky error
  logic [2:0]  rem_q, rem_d;            // Sub-accesses left
  dmp_pkg::dmp_state_e st_q, st_d;      // Sequencer
  // Bus capture registers
  logic              awg_q, awg_d, wg_q, wg_d, arg_q, arg_d;
  logic [ADDR_W-1:0] awa_q, awa_d, ara_q, ara_d;
  logic [31:0]       wd_q, wd_d;
  logic [3:0]        ws_q, ws_d;
  logic              cwr_q, cwr_d;      // Current access is a write
  // Registered outputs
  logic        awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
  logic        bv_q, bv_d, rv_q, rv_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  dmp_pkg::dmp_mreq_s mq_q, mq_d;
  logic        mv_q, mv_d;
  // Derived terms
  logic [31:0] step;                    // Address step for one access
  logic [2:0]  nsub;                    // Accesses per data word
  logic        misal;                   // Address not aligned to size
  logic [31:0] rmerge;                  // Read data merged by lane

  // Byte strobes; big-endian flips the lane index within the word
  function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
    logic [1:0] l;
    l = a;
    lanes = 4'hf;
    if (BIG_ENDIAN) begin
      l = a ^ ((sz == dmp_pkg::SZ_BYTE) ? 2'h3 : 2'h2);
    end
    if (sz == dmp_pkg::SZ_BYTE) begin
      lanes = 4'h1 << l;
    end else if (sz == dmp_pkg::SZ_HALF) begin
      lanes = l[1] ? 4'hc : 4'h3;
    end
  endfunction

  // Build one sub-access; low bits the size cannot use are dropped
  function automatic dmp_pkg::dmp_mreq_s mk_req(input logic [31:0] a,
      input logic [2:0] sz, input logic wr, input logic [31:0] d);
    logic [1:0] m;
    m = (sz == dmp_pkg::SZ_BYTE) ? 2'h3 : (sz == dmp_pkg::SZ_HALF) ? 2'h2 : 2'h0;
    mk_req.addr  = {a[31:2], a[1:0] & m};
    mk_req.wdata = d;
    mk_req.strb  = lanes(sz, a[1:0]);
    mk_req.size  = sz;
    mk_req.write = wr;
  endfunction

  // Merge strobed masking of a register by byte
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
      input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      bmerge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_rlane
      assign rmerge[g*8 +: 8] = mq_q.strb[g] ? mem_rdata[g*8 +: 8] : drw_q[g*8 +: 8];
    end
  endgenerate

  // Size-dependent step, count and alignment
  always_comb begin
    step  = 32'h00000004;
    nsub  = 3'h1;
    misal = 1'b0;
    if (size_q == dmp_pkg::SZ_BYTE) begin
      step = 32'h00000001;
    end else if (size_q == dmp_pkg::SZ_HALF) begin
      step  = 32'h00000002;
      misal = tar_q[0];
    end else begin
      misal = |tar_q[1:0];
    end
    if (inc_q == dmp_pkg::INC_PACKED) begin
      nsub = (size_q == dmp_pkg::SZ_BYTE) ? 3'h4 :
             (size_q == dmp_pkg::SZ_HALF) ? 3'h2 : 3'h1;
    end
  end

  // Sequencer and register file next state
  always_comb begin
    logic start;
    logic set_err;
    logic clr_err;
    start   = 1'b0;
    set_err = 1'b0;
    clr_err = 1'b0;
    size_d = size_q; inc_d = inc_q; tar_d = tar_q; drw_d = drw_q;
    rem_d = rem_q; st_d = st_q;
    awg_d = awg_q; wg_d = wg_q; arg_d = arg_q;
    awa_d = awa_q; ara_d = ara_q; wd_d = wd_q; ws_d = ws_q; cwr_d = cwr_q;
    bv_d = bv_q; rv_d = rv_q; br_d = br_q; rr_d = rr_q; rd_d = rd_q;
    mq_d = mq_q; mv_d = mv_q;
    // Channels are captured independently, in either order
    if (awvalid && awr_q) begin
      awg_d = 1'b1;
      awa_d = awaddr;
    end
    if (wvalid && wr_q) begin
      wg_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (arvalid && arr_q) begin
      arg_d = 1'b1;
      ara_d = araddr;
    end
    unique case (st_q)
      dmp_pkg::ST_IDLE: begin
        // Writes go first when both directions are waiting
        if (awg_q && wg_q) begin
          awg_d = 1'b0;
          wg_d  = 1'b0;
          cwr_d = 1'b1;
          br_d  = dmp_pkg::RESP_OKAY;
          bv_d  = 1'b1;
          st_d  = dmp_pkg::ST_RESP;
          unique case (awa_q[11:0])
            dmp_pkg::CTRL_OFF: begin
              // all three sizes, reserved codes ignored
              if (MULTI_SIZE && ws_q[0] &&
                  wd_q[dmp_pkg::CTRL_SIZE_LSB +: 3] <= dmp_pkg::SZ_WORD) begin
                size_d = wd_q[dmp_pkg::CTRL_SIZE_LSB +: 3];
              end
              if (ws_q[0] && (wd_q[dmp_pkg::CTRL_INC_LSB +: 2] != 2'h3) &&
                  (MULTI_SIZE || wd_q[dmp_pkg::CTRL_INC_LSB +: 2] != dmp_pkg::INC_PACKED)) begin
                inc_d = wd_q[dmp_pkg::CTRL_INC_LSB +: 2];
              end
            end
            dmp_pkg::ADDR_OFF: tar_d = bmerge(tar_q, wd_q, ws_q);
            dmp_pkg::STAT_OFF: clr_err = ws_q[0] & wd_q[0];
            dmp_pkg::DATA_OFF: begin
              drw_d = bmerge(drw_q, wd_q, ws_q);
              start = 1'b1;
              bv_d  = 1'b0;
            end
            dmp_pkg::CFG_OFF: br_d = dmp_pkg::RESP_OKAY;
            default: br_d = dmp_pkg::RESP_DECERR;
          endcase
        end else if (arg_q) begin
          arg_d = 1'b0;
          cwr_d = 1'b0;
          rr_d  = dmp_pkg::RESP_OKAY;
          rv_d  = 1'b1;
          rd_d  = 32'h00000000;
          st_d  = dmp_pkg::ST_RESP;
          unique case (ara_q[11:0])
            dmp_pkg::CTRL_OFF: rd_d = {26'h0, inc_q, 1'b0, size_q};
            dmp_pkg::ADDR_OFF: rd_d = tar_q;
            dmp_pkg::STAT_OFF: rd_d = {31'h0, sticky_q};
            dmp_pkg::DATA_OFF: begin
              start = 1'b1;
              rv_d  = 1'b0;
            end
            dmp_pkg::CFG_OFF:  rd_d = {31'h0, BIG_ENDIAN};
            default: rr_d = dmp_pkg::RESP_DECERR;
          endcase
        end
        if (start) begin
          if (MISALIGN_FAULT && misal) begin
            set_err = 1'b1;
            bv_d = cwr_d;
            rv_d = ~cwr_d;
            br_d = dmp_pkg::RESP_SLVERR;
            rr_d = dmp_pkg::RESP_SLVERR;
          end else begin
            mq_d  = mk_req(tar_q, size_q, cwr_d, drw_d);
            mv_d  = 1'b1;
            rem_d = nsub;
            st_d  = dmp_pkg::ST_MEM;
          end
        end
      end
      dmp_pkg::ST_MEM: begin
        // held here until the last answer
        if (mem_ack) begin
          if (mem_err) begin
            // stop sequence at the failing access
            set_err = 1'b1;
            mv_d = 1'b0;
            bv_d = cwr_q;
            rv_d = ~cwr_q;
            br_d = dmp_pkg::RESP_SLVERR;
            rr_d = dmp_pkg::RESP_SLVERR;
            rd_d = drw_q;
            st_d = dmp_pkg::ST_RESP;
          end else begin
            if (!cwr_q) begin
              drw_d = rmerge;
            end
            if (inc_q != dmp_pkg::INC_OFF) begin
              tar_d = tar_q + step;
            end
            rem_d = rem_q - 3'h1;
            // answer only once the word is complete
            if (rem_q == 3'h1) begin
              mv_d = 1'b0;
              bv_d = cwr_q;
              rv_d = ~cwr_q;
              br_d = dmp_pkg::RESP_OKAY;
              rr_d = dmp_pkg::RESP_OKAY;
              rd_d = drw_d;
              st_d = dmp_pkg::ST_RESP;
            end else begin
              mq_d = mk_req(tar_d, size_q, cwr_q, drw_q);
            end
          end
        end
      end
      dmp_pkg::ST_RESP: begin
        if ((bv_q && bready) || (rv_q && rready)) begin
          bv_d = 1'b0;
          rv_d = 1'b0;
          st_d = dmp_pkg::ST_IDLE;
        end
      end
      default: st_d = dmp_pkg::ST_IDLE;
    endcase
    if (!MULTI_SIZE) begin
      size_d = dmp_pkg::SZ_WORD;
    end
    // Set beats clear in the same cycle
    sticky_d = (sticky_q & ~clr_err) | set_err;
    // Each channel ready only until its item is held
    awr_d = ~awg_d;
    wr_d  = ~wg_d;
    arr_d = ~arg_d;
  end

  // State registers; reset wins over the enable, otherwise a low enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      size_q <= dmp_pkg::SIZE_RST; inc_q <= dmp_pkg::INC_RST;
      tar_q <= dmp_pkg::ADDR_RST; drw_q <= dmp_pkg::DATA_RST;
      sticky_q <= 1'b0; rem_q <= 3'h0; st_q <= dmp_pkg::ST_IDLE;
      awg_q <= 1'b0; wg_q <= 1'b0; arg_q <= 1'b0;
      awa_q <= '0; ara_q <= '0; wd_q <= 32'h0; ws_q <= 4'h0; cwr_q <= 1'b0;
      awr_q <= 1'b0; wr_q <= 1'b0; arr_q <= 1'b0;
      bv_q <= 1'b0; rv_q <= 1'b0; br_q <= 2'h0; rr_q <= 2'h0; rd_q <= 32'h0;
      mq_q <= '0; mv_q <= 1'b0;
    end else if (ce) begin
      size_q <= size_d; inc_q <= inc_d; tar_q <= tar_d; drw_q <= drw_d;
      sticky_q <= sticky_d; rem_q <= rem_d; st_q <= st_d;
      awg_q <= awg_d; wg_q <= wg_d; arg_q <= arg_d;
      awa_q <= awa_d; ara_q <= ara_d; wd_q <= wd_d; ws_q <= ws_d; cwr_q <= cwr_d;
      awr_q <= awr_d; wr_q <= wr_d; arr_q <= arr_d;
      bv_q <= bv_d; rv_q <= rv_d; br_q <= br_d; rr_q <= rr_d; rd_q <= rd_d;
      mq_q <= mq_d; mv_q <= mv_d;
    end
  end

  // Outputs straight from flops
  assign awready = awr_q;
  assign wready  = wr_q;
  assign arready = arr_q;
  assign bvalid  = bv_q;
  assign bresp   = br_q;
  assign rvalid  = rv_q;
  assign rresp   = rr_q;
  assign rdata   = rd_q;
  assign mem_req = mq_q;
  assign mem_valid = mv_q;
  assign sticky_error_flag = sticky_q;

  // Checks
  a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    mv_q && mem_ack && mem_err && ce |=> sticky_q) else $error("error not sticky");
  a_err_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    mv_q && mem_ack && mem_err && ce |=> !mv_q ##0
    ((bv_q && br_q == 2'h2) || (rv_q && rr_q == 2'h2))) else $error("error not answered");
  a_tar_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    mv_q && mem_ack && mem_err && ce |=> tar_q == $past(tar_q)) else $error("address moved");
  a_tar_step: assert property (@(posedge aclk) disable iff (!aresetn)
    mv_q && mem_ack && !mem_err && ce && inc_q != 2'h0 |=>
    tar_q == $past(tar_q) + $past(step)) else $error("bad address step");
  a_word_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !MULTI_SIZE |-> size_q == 3'h2) else $error("size not word");
  a_byte_strb: assert property (@(posedge aclk) disable iff (!aresetn)
    mv_q && mq_q.size == 3'h0 |-> $onehot(mq_q.strb)) else $error("byte strobe");
  a_le_lane: assert property (@(posedge aclk) disable iff (!aresetn)
    mv_q && !BIG_ENDIAN && mq_q.size == 3'h0 |-> mq_q.strb[mq_q.addr[1:0]])
    else $error("byte lane");
  a_ascend: assert property (@(posedge aclk) disable iff (!aresetn)
    mv_q && mem_ack && !mem_err && ce && rem_q > 3'h1 && inc_q == 2'h2 |=>
    mv_q && mq_q.addr == $past(mq_q.addr) + $past(step)) else $error("not ascending");
  a_pending: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == dmp_pkg::ST_MEM |-> !bv_q && !rv_q && mv_q) else $error("answered early");
endmodule

// *** inc/dmp_pkg.sv ***
// Package for the debug memory port sizing and packing block
// Notes on behaviour
// - Memory error answers debug port with error
// - Sub-word support means byte, halfword, word
// - Size codes: byte 0, halfword 1, word 2
// - Word-only build: size reads fixed word
// - Endianness little or byte-invariant big, reported
// - Byte lanes follow address low bits
// - Halfword lanes follow address bit one
// - Word access uses all lanes; misalign policy
// - Faulting misalign rejects and sets sticky error
// - Increment mode bits 5:4, size 2:0
// - Packed gives one, two or four accesses
// - Sub-word support implies packed operation
// - Packed advances address by access size
// - Packed sub-accesses ascend, lanes by address
// - Endianness value always readable
// - System memory ports should offer sub-word sizes
// - No address advance on error
// - Failed sub-access stops sequence, reports error
// - Packed read answers after full word filled
package dmp_pkg;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] ADDR_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  localparam logic [11:0] DATA_OFF = 12'h00c;
  localparam logic [11:0] CFG_OFF  = 12'h0f4;
  // Control status word fields
  localparam int          CTRL_SIZE_LSB = 0;
  localparam int          CTRL_INC_LSB  = 4;
  localparam logic [2:0]  SZ_BYTE      = 3'h0;
  localparam logic [2:0]  SZ_HALF      = 3'h1;
  localparam logic [2:0]  SZ_WORD      = 3'h2;
  localparam logic [1:0]  INC_OFF      = 2'h0;
  localparam logic [1:0]  INC_SINGLE   = 2'h1;
  localparam logic [1:0]  INC_PACKED   = 2'h2;
  localparam logic [2:0]  SIZE_RST     = 3'h2;
  localparam logic [1:0]  INC_RST      = 2'h0;
  localparam logic [31:0] ADDR_RST     = 32'h00000000;
  localparam logic [31:0] DATA_RST     = 32'h00000000;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;
  // One memory sub-access
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic [2:0]  size;
    logic        write;
  } dmp_mreq_s;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEM  = 3'b010,
    ST_RESP = 3'b100
  } dmp_state_e;
endpackage

// *** tb/dmp_mem_model.sv ***
// Behavioural memory behind the debug memory port, with wait states and error injection
module dmp_mem_model (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Memory side of the port
  input  wire dmp_pkg::dmp_mreq_s mem_req,
  input  wire logic          mem_valid,
  output logic               mem_ack,
  output logic               mem_err,
  output logic [31:0]        mem_rdata,
  // Test controls
  input  wire logic [3:0]    delay,
  input  wire logic [31:0]   err_addr,
  output logic [31:0]        n_acc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem   [64];  // Byte storage, low six address bits
  logic [31:0] log_a [64];  // Address of each completed sub-access
  logic [3:0]  log_s [64];  // Strobes of each completed sub-access
  logic [3:0]  wait_q;      // Wait states spent on the current offer

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'h00;
    end
  end

  // Answer each offer after delay wait states; idle data toggles so stale values never match
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      wait_q    <= 4'h0;
      n_acc     <= 32'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_rdata <= ~mem_rdata;
      mem_ack   <= 1'b0;
      mem_err   <= 1'b0;
      if (mem_valid && !mem_ack) begin
        if (wait_q < delay) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          wait_q <= 4'h0;
          mem_ack <= 1'b1;
          mem_err <= (mem_req.addr == err_addr);
          log_a[n_acc[5:0]] <= mem_req.addr;
          log_s[n_acc[5:0]] <= mem_req.strb;
          n_acc <= n_acc + 32'h1;
          for (int i = 0; i < 4; i++) begin
            if (mem_req.strb[i]) begin
              mem_rdata[8*i+:8] <= mem[{mem_req.addr[5:2], 2'(i)}];
              if (mem_req.write && mem_req.addr != err_addr) begin
                mem[{mem_req.addr[5:2], 2'(i)}] <= mem_req.wdata[8*i+:8];
              end
            end
          end
        end
      end
    end
  end
endmodule

// *** tb/dmp_mem_port_tb_top.sv ***
// Self-checking bench for the debug memory port over its register bus
module dmp_mem_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock and reset
  logic               aclk      = 1'b0;
  logic               aresetn   = 1'b0;
  // Register bus, driven by the tasks below
  logic [11:0]        awaddr    = 12'h000;
  logic [11:0]        araddr    = 12'h000;
  logic [31:0]        wdata     = 32'h0;
  logic [3:0]         wstrb     = 4'hf;
  logic               awvalid   = 1'b0;
  logic               wvalid    = 1'b0;
  logic               bready    = 1'b0;
  logic               arvalid   = 1'b0;
  logic               rready    = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  // Memory side and model controls
  dmp_pkg::dmp_mreq_s mem_req;
  logic               mem_valid, mem_ack, mem_err, sticky_error_flag;
  logic [31:0]        mem_rdata, n_acc;
  logic [31:0]        err_addr  = 32'hffffffff;
  logic [3:0]         delay     = 4'h0;
  // Scoreboard
  int                 fails     = 0;
  int                 checks    = 0;
  int                 base;
  logic [1:0]         r;
  logic [31:0]        d;

  always #25 aclk = ~aclk;

  dmp_mem_port #(.ADDR_W(12), .MULTI_SIZE(1'b1), .BIG_ENDIAN(1'b0), .MISALIGN_FAULT(1'b1))
  u_dmp_mem_port (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mem_req(mem_req), .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata), .sticky_error_flag(sticky_error_flag));

  dmp_mem_model u_dmp_mem_model (
    .aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .mem_valid(mem_valid),
    .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .delay(delay), .err_addr(err_addr), .n_acc(n_acc));

  // Compare one value, count it, report a mismatch at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write: address and data offered together, each dropped when taken, bready held to answer
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done && n < 2000) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
    if (!done) fails++;
  endtask

  // Read: address held until taken, rready held until the data comes
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done && n < 2000) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
    if (!done) fails++;
  endtask

  // Little-endian word as stored in the model
  function automatic logic [31:0] memw(input int a);
    return {u_dmp_mem_model.mem[a+3], u_dmp_mem_model.mem[a+2],
            u_dmp_mem_model.mem[a+1], u_dmp_mem_model.mem[a]};
  endfunction

  // Sub-access count, ascending addresses and strobes worked out from size and address
  task automatic chk_seq(input int b, input int n, input logic [31:0] a0, input int sz);
    logic [31:0] a;
    logic [3:0]  s;
    chk("count", 32'(n), n_acc - 32'(b));
    for (int i = 0; i < n; i++) begin
      a = a0 + 32'(i * sz);
      s = (sz == 1) ? 4'h1 : (sz == 2) ? 4'h3 : 4'hf;
      chk("addr", a, u_dmp_mem_model.log_a[b+i]);
      chk("strb", 32'(s << a[1:0]), 32'(u_dmp_mem_model.log_s[b+i]));
    end
  endtask

  // Print counts and verdict, end the run
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped place
    rd(dmp_pkg::CTRL_OFF, d, r); chk("ctrl", 32'h2, d);
    rd(dmp_pkg::ADDR_OFF, d, r); chk("addr", 32'h0, d);
    rd(dmp_pkg::CFG_OFF, d, r); chk("cfg", 32'h0, d);
    rd(12'h010, d, r); chk("decerr", 32'(dmp_pkg::RESP_DECERR), 32'(r));
    wr(dmp_pkg::CTRL_OFF, 32'h3, r); rd(dmp_pkg::CTRL_OFF, d, r); chk("rsvd", 32'h2, d);
    // Packed halfword write from 0
    wr(dmp_pkg::CTRL_OFF, 32'h21, r); wr(dmp_pkg::ADDR_OFF, 32'h0, r); base = n_acc;
    wr(dmp_pkg::DATA_OFF, 32'ha1b2c3d4, r); chk("bresp", 32'h0, 32'(r));
    chk("mem0", 32'ha1b2c3d4, memw(0));
    chk_seq(base, 2, 32'h0, 2);
    rd(dmp_pkg::ADDR_OFF, d, r); chk("addr", 32'h4, d);
    // Packed byte write from 2 with a slow memory
    delay <= 4'h3;
    wr(dmp_pkg::CTRL_OFF, 32'h20, r); wr(dmp_pkg::ADDR_OFF, 32'h2, r); base = n_acc;
    wr(dmp_pkg::DATA_OFF, 32'h44332211, r);
    chk_seq(base, 4, 32'h2, 1);
    chk("mem0", 32'h4433c3d4, memw(0));
    chk("mem4", 32'h00002211, memw(4));
    rd(dmp_pkg::ADDR_OFF, d, r); chk("addr", 32'h6, d);
    // Packed halfword read from 6; both halves differ from the word still held
    wr(dmp_pkg::CTRL_OFF, 32'h21, r); wr(dmp_pkg::ADDR_OFF, 32'h6, r); base = n_acc;
    rd(dmp_pkg::DATA_OFF, d, r); chk("pread", 32'h00000000, d);
    chk_seq(base, 2, 32'h6, 2);
    // Plain byte reads on every lane, address held
    delay <= 4'h0;
    wr(dmp_pkg::CTRL_OFF, 32'h00, r);
    for (int k = 0; k < 4; k++) begin
      wr(dmp_pkg::ADDR_OFF, 32'(k), r);
      rd(dmp_pkg::DATA_OFF, d, r);
      chk("lane", (32'h4433c3d4 >> (8 * k)) & 32'hff, (d >> (8 * k)) & 32'hff);
    end
    rd(dmp_pkg::ADDR_OFF, d, r); chk("addr", 32'h3, d);
    // Plain halfword read of the lower half of the next word
    wr(dmp_pkg::CTRL_OFF, 32'h01, r); wr(dmp_pkg::ADDR_OFF, 32'h4, r);
    rd(dmp_pkg::DATA_OFF, d, r); chk("half", 32'h2211, d & 32'hffff);
    // Word write with single increment; word size set before data access
    wr(dmp_pkg::CTRL_OFF, 32'h12, r); wr(dmp_pkg::ADDR_OFF, 32'h8, r); base = n_acc;
    wr(dmp_pkg::DATA_OFF, 32'hdeadbeef, r); chk("mem8", 32'hdeadbeef, memw(8));
    chk_seq(base, 1, 32'h8, 4);
    rd(dmp_pkg::ADDR_OFF, d, r); chk("addr", 32'hc, d);
    // Misaligned halfword faults without a memory access
    wr(dmp_pkg::CTRL_OFF, 32'h01, r); wr(dmp_pkg::ADDR_OFF, 32'h1, r); base = n_acc;
    wr(dmp_pkg::DATA_OFF, 32'h0, r); chk("fault", 32'(dmp_pkg::RESP_SLVERR), 32'(r));
    chk("count", 32'(base), n_acc);
    chk("sticky", 32'h1, 32'(sticky_error_flag));
    rd(dmp_pkg::STAT_OFF, d, r); chk("stat", 32'h1, d & 32'h1);
    wr(dmp_pkg::STAT_OFF, 32'h1, r); rd(dmp_pkg::STAT_OFF, d, r); chk("clr", 32'h0, d & 32'h1);
    // Memory error on the third byte of a packed write
    wr(dmp_pkg::CTRL_OFF, 32'h20, r); wr(dmp_pkg::ADDR_OFF, 32'h10, r); base = n_acc;
    err_addr <= 32'h12;
    wr(dmp_pkg::DATA_OFF, 32'h55667788, r); chk("merr", 32'(dmp_pkg::RESP_SLVERR), 32'(r));
    chk_seq(base, 3, 32'h10, 1);
    rd(dmp_pkg::ADDR_OFF, d, r); chk("addr", 32'h12, d);
    chk("sticky", 32'h1, 32'(sticky_error_flag));
    summarize();
  end
endmodule
